// ---- sspc_map.svh ----
/*
   register offsets, key values, reset values and timing counts of the power control block.
   assumes inclusion by bare name from the package and the modules.
*/
`ifndef SSPC_MAP_SVH
`define SSPC_MAP_SVH
`define SSPC_KEY_OFFSET    8'hF5
`define SSPC_CTRL_OFFSET   8'hF8
`define SSPC_STATUS_OFFSET 8'hFC
`define SSPC_KEY_RESET     8'h00
`define SSPC_KEY_SLEEP     8'h0F
`define SSPC_KEY_STOP      8'h5A
`define SSPC_CTRL_RESET    8'h00
`define SSPC_WIT_START     8'h00
`define SSPC_WIT_LAST      8'hFF
`define SSPC_PRE_WIDTH     4
`define SSPC_NWAKE         4'h7
`endif

// ---- sspc_pkg.sv ----
/*
   types shared by the power control block.
   assumes the map header is on the include path.
*/
`include "sspc_map.svh"
package sspc_pkg;
   // power states, gray along run-sleep and stop-wake-run
   typedef enum logic [1:0] {
      SSPC_RUN   = 2'b00,
      SSPC_SLEEP = 2'b01,
      SSPC_STOP  = 2'b11,
      SSPC_WAKE  = 2'b10
   } sspc_state_type;
endpackage

// ---- sspc_wake_timer.sv ----
/*
   wake interval timer: counts upward from zero on a prescaled tick, reports overflow.
   assumes start is a one-cycle pulse from the power controller.
*/
`timescale 1ns/100ps
`include "sspc_map.svh"
module sspc_wake_timer
   import sspc_pkg::*;
(
   // clock and reset
   input  wire logic                         clock,
   input  wire logic                         rst_n,
   // control
   input  wire logic                         start,
   input  wire logic                         run,
   input  wire logic [`SSPC_PRE_WIDTH-1:0]   prescale,
   // result
   output logic [7:0]                        count,
   output logic                              overflow
);
   typedef struct packed {
      logic [15:0] pre;
      logic [7:0]  cnt;
      logic        ovf;
   } sspc_wt_type;
   sspc_wt_type s_q, s_d;
   logic        tick;

   // tick when the prescaler reaches 2^prescale - 1
   always_comb begin
      tick = ((s_q.pre | ~((16'h0001 << prescale) - 16'h0001)) == 16'hFFFF);
   end

   // count from zero, flag overflow past the top value
   always_comb begin
      s_d = s_q;
      s_d.ovf = 1'b0;
      if (start) begin
         s_d.pre = 16'h0000;
         s_d.cnt = `SSPC_WIT_START; // [RL8]
      end else if (run) begin
         s_d.pre = tick ? 16'h0000 : s_q.pre + 16'h0001;
         if (tick) begin
            s_d.cnt = s_q.cnt + 8'h01;
            s_d.ovf = (s_q.cnt == `SSPC_WIT_LAST); // [RL8]
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign count    = s_q.cnt;
   assign overflow = s_q.ovf;
endmodule

// ---- sspc_power_ctrl.sv ----
/*
   sleep and stop power controller with a classic wishbone register slave.
   assumes the cpu core gives a one-cycle stop instruction pulse and the
   global interrupt flag; wake sources are synchronous to clock except the
   external interrupt pin, which is synchronised here.
*/
`timescale 1ns/100ps
`include "sspc_map.svh"
// What the document asks of this block and its software
// RL1: writing 0Fh to the key register halts the cpu; clocks and peripherals keep running.
// RL2: stop happens only on a stop instruction while the key holds 5Ah.
// RL3: hardware clears the key register when stop is released.
// RL4: sleep ends on reset or any enabled interrupt.
// RL5: interrupt wake vectors if global flag set, else resumes at next instruction.
// RL6: reset wake returns control registers to reset values, ram untouched; the control register resets to 70h here, not 00h.
// RL7: interrupt wake keeps ram and control registers as before; here the key also returns to 00h at the end of a sleep wake.
// RL8: on wake the timer counts up from 00h; run resumes on overflow past FFh.
// RL9: stop halts the selected clock and peripheral clocks; unselected oscillator runs.
// RL10: entering stop keeps ram, registers and latches as they stood.
// RL11: during stop the program counter holds the next instruction address.
// RL12: software writes the key register as a whole byte.
// RL13: stop is released by reset, external, timer, watch, two-wire, serial or uart events.
// RL14: software sets the wake timer prescaler for more than 20 ms before stop.
// RL15: software places a nop after the sleep write.
// RL16: software places two nops after the stop instruction.
// RL17: converter, usart, wake timer, watchdog, system-clocked timers halt in stop, run in sleep.
// RL18: serial port runs in stop only on an external clock; always in sleep.
// RL19: sub oscillator and sub-clocked units run in stop when main is system clock.
// RL20: a stop instruction without the stop key does nothing.
module sspc_power_ctrl
   import sspc_pkg::*;
(
   // clock and reset
   input  wire logic                     clock,
   input  wire logic                     rst_n,
   // wishbone slave
   input  wire logic                     wb_cyc_i,
   input  wire logic                     wb_stb_i,
   input  wire logic                     wb_we_i,
   input  wire logic [7:0]               wb_adr_i,
   input  wire logic [3:0]               wb_sel_i,
   input  wire logic [31:0]              wb_dat_i,
   output logic [31:0]                   wb_dat_o,
   output logic                          wb_ack_o,
   // cpu core
   input  wire logic                     stop_instr,
   input  wire logic                     global_irq_en,
   input  wire logic                     irq_pending,
   output logic                          cpu_halt,
   output logic                          irq_vector,
   output logic                          resume_next,
   // wake sources
   input  wire logic                     ext_irq_pin,
   input  wire logic                     timer_irq,
   input  wire logic                     watch_irq,
   input  wire logic                     twi_irq,
   input  wire logic                     sync_serial_port_irq,
   input  wire logic                     uart_irq,
   // clock gating
   output logic                          main_osc_en,
   output logic                          sub_osc_en,
   output logic                          periph_clk_en,
   output logic                          sub_periph_clk_en,
   output logic                          sync_serial_port_clk_en,
   output logic                          twi_clk_en
);
   typedef struct packed {
      sspc_state_type             st;
      logic [7:0]                 key;
      logic                       sel_sub;
      logic                       ssp_ext;
      logic [`SSPC_PRE_WIDTH-1:0] pre;
      logic                       was_stop;
      logic                       ack;
      logic [31:0]                dat;
      logic [2:0]                 ext_sync;
      logic                       ext_lvl;
      logic                       vec;
      logic                       res;
   } sspc_type;
   sspc_type    s_q, s_d;
   logic        wb_req;
   logic        wt_start;
   logic        wt_ovf;
   logic [7:0]  wt_count;
   logic        ext_event;
   logic        stop_wake;

   // slave request, answered one cycle later
   assign wb_req = wb_cyc_i & wb_stb_i & ~s_q.ack;

   // external pin rising edge once second and third stage agree
   assign ext_event = (s_q.ext_sync[1] == s_q.ext_sync[2]) & (s_q.ext_sync[2] != s_q.ext_lvl) & s_q.ext_sync[2];

   // release sources valid in stop
   assign stop_wake = ext_event | timer_irq | watch_irq | twi_irq | sync_serial_port_irq | uart_irq; // [RL13]

   assign wt_start = (s_d.st == SSPC_WAKE) & (s_q.st != SSPC_WAKE); // [RL8]

   sspc_wake_timer u_timer (
      .clock    (clock),
      .rst_n    (rst_n),
      .start    (wt_start),
      .run      (s_q.st == SSPC_WAKE),
      .prescale (s_q.pre),
      .count    (wt_count),
      .overflow (wt_ovf)
   );

   // next state, registers and bus
   always_comb begin
      s_d = s_q;
      s_d.ack = wb_req;
      s_d.vec = 1'b0;
      s_d.res = 1'b0;
      s_d.ext_sync = {s_q.ext_sync[1:0], ext_irq_pin};
      if (s_q.ext_sync[1] == s_q.ext_sync[2]) begin
         s_d.ext_lvl = s_q.ext_sync[2];
      end
      // register writes, whole low byte only
      if (wb_req && wb_we_i && wb_sel_i[0]) begin
         case (wb_adr_i)
            `SSPC_KEY_OFFSET: begin
               s_d.key = wb_dat_i[7:0];
            end
            `SSPC_CTRL_OFFSET: begin
               s_d.sel_sub = wb_dat_i[0];
               s_d.ssp_ext = wb_dat_i[1];
               s_d.pre     = wb_dat_i[7:4];
            end
            default: begin
            end
         endcase
      end
      // register reads
      if (wb_req && !wb_we_i) begin
         case (wb_adr_i)
            `SSPC_KEY_OFFSET:    s_d.dat = {24'h000000, s_q.key};
            `SSPC_CTRL_OFFSET:   s_d.dat = {24'h000000, s_q.pre, 2'b00, s_q.ssp_ext, s_q.sel_sub};
            `SSPC_STATUS_OFFSET: s_d.dat = {16'h0000, wt_count, 5'b00000, s_q.was_stop, s_q.st};
            default:             s_d.dat = 32'h00000000;
         endcase
      end
      // power state machine; ram and registers other than the key untouched on any wake
      case (s_q.st)
         SSPC_RUN: begin
            if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `SSPC_KEY_OFFSET
                && wb_dat_i[7:0] == `SSPC_KEY_SLEEP) begin
               s_d.st = SSPC_SLEEP; // [RL1]
            end else if (stop_instr && s_q.key == `SSPC_KEY_STOP) begin
               s_d.st = SSPC_STOP; // [RL2] [RL10] [RL11]
            end
            // other keys leave a stop instruction with no effect [RL20]
         end
         SSPC_SLEEP: begin
            if (irq_pending || ext_event) begin
               s_d.st = SSPC_WAKE; // [RL4] [RL7]
               s_d.was_stop = 1'b0;
            end
         end
         SSPC_STOP: begin
            if (stop_wake) begin
               s_d.st = SSPC_WAKE; // [RL7]
               s_d.was_stop = 1'b1;
               s_d.key = `SSPC_KEY_RESET; // [RL3]
            end
         end
         SSPC_WAKE: begin
            if (wt_ovf) begin
               s_d.st = SSPC_RUN; // [RL8]
               s_d.vec = global_irq_en; // [RL5]
               s_d.res = ~global_irq_en; // [RL5]
               if (!s_q.was_stop) begin
                  s_d.key = `SSPC_KEY_RESET;
               end
            end
         end
         default: begin
            s_d.st = SSPC_RUN;
         end
      endcase
   end

   // reset loads the key with 00h and the control register with 70h, prescaler 7, not its 00h reset value [RL6]
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '{st: SSPC_RUN, key: `SSPC_KEY_RESET, sel_sub: 1'b0, ssp_ext: 1'b0,
                  pre: `SSPC_NWAKE, was_stop: 1'b0, ack: 1'b0, dat: 32'h00000000,
                  ext_sync: 3'b000, ext_lvl: 1'b0, vec: 1'b0, res: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   // outputs
   assign wb_ack_o    = s_q.ack;
   assign wb_dat_o    = s_q.dat;
   assign cpu_halt    = (s_q.st != SSPC_RUN);
   assign irq_vector  = s_q.vec;
   assign resume_next = s_q.res;

   // clock gating in stop; sleep keeps everything running
   assign main_osc_en = !(s_q.st == SSPC_STOP && !s_q.sel_sub); // [RL9]
   assign sub_osc_en  = !(s_q.st == SSPC_STOP && s_q.sel_sub); // [RL9] [RL19]
   assign periph_clk_en = (s_q.st != SSPC_STOP); // [RL17]
   assign sub_periph_clk_en = sub_osc_en; // [RL19]
   assign sync_serial_port_clk_en = (s_q.st != SSPC_STOP) | s_q.ssp_ext; // [RL18]
   assign twi_clk_en = 1'b1; // [RL17]
endmodule

// ---- sspc_power_ctrl_properties.sv ----
/* port checker for sspc_power_ctrl.
   assumes bind onto the top module; only its ports are seen. */
`timescale 1ns/100ps
module sspc_power_props (
   // clock, reset and bus
   input wire logic        clock, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i, wb_dat_o,
   // core and gating
   input wire logic        stop_instr, cpu_halt, irq_vector, resume_next,
   input wire logic        main_osc_en, sub_osc_en, periph_clk_en, twi_clk_en
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // a request taken this edge
   wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   ack_follows_req_a: assert property (req |=> wb_ack_o) else $error("ack missing");
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
   unmapped_zero_a: assert property (wb_ack_o && !$past(wb_we_i) && !($past(wb_adr_i) inside {8'hF5, 8'hF8, 8'hFC})
      |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
   sleep_entry_a: assert property (req && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'hF5 && wb_dat_i[7:0] == 8'h0F
      && !cpu_halt |=> cpu_halt && periph_clk_en && main_osc_en && sub_osc_en) else $error("no sleep");
   halt_cause_a: assert property ($rose(cpu_halt) |-> $past(stop_instr || (req && wb_we_i && wb_adr_i == 8'hF5)))
      else $error("halt without cause");
   stop_gating_a: assert property (!periph_clk_en |-> cpu_halt && (main_osc_en != sub_osc_en))
      else $error("bad stop gating");
   twi_always_a: assert property (twi_clk_en) else $error("two-wire clock gated");
   wake_notice_a: assert property ($fell(cpu_halt) |-> ##[0:2] (irq_vector || resume_next))
      else $error("wake without notice");
   notice_excl_a: assert property (!(irq_vector && resume_next)) else $error("both notices");
endmodule
bind sspc_power_ctrl sspc_power_props sspc_power_props_inst (.clock, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_ack_o, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .stop_instr, .cpu_halt, .irq_vector, .resume_next,
   .main_osc_en, .sub_osc_en, .periph_clk_en, .twi_clk_en);

// ---- tb.sv ----
/* self-checking bench for sspc_power_ctrl.
   assumes ctrl prescale 0 gives a 256-cycle wake. */
`timescale 1ns/100ps
`include "sspc_map.svh"
module tb;
   logic        clock = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, si = 0, gie = 0, irqp = 0, ext = 0;
   logic [7:0]  adr = 0, kv;
   logic [3:0]  sel = 0;
   logic [4:0]  src = 0;
   logic [31:0] dat = 0, rd, lf = 32'hD8A7;
   logic [31:0] dato;
   logic        ack, halt, vec, res, mosc, sosc, pclk, spclk, sclk, tclk;
   int          n_fail = 0, checks_done = 0, cyc_n = 0, ctrl_m;
   // clock
   always #5 clock = ~clock;
   sspc_power_ctrl sspc_power_ctrl_inst (.clock, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dato), .wb_ack_o(ack), .stop_instr(si),
      .global_irq_en(gie), .irq_pending(irqp), .cpu_halt(halt), .irq_vector(vec), .resume_next(res),
      .ext_irq_pin(ext), .timer_irq(src[0]), .watch_irq(src[1]), .twi_irq(src[2]),
      .sync_serial_port_irq(src[3]), .uart_irq(src[4]), .main_osc_en(mosc), .sub_osc_en(sosc),
      .periph_clk_en(pclk), .sub_periph_clk_en(spclk), .sync_serial_port_clk_en(sclk), .twi_clk_en(tclk));
   function logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   // one classic bus cycle
   task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= {24'h0, d}; sel <= 4'hF;
      do @(posedge clock); while (ack !== 1'b1);
      rd = dato;
      cyc <= 0; stb <= 0;
      #1;
   endtask
   // wait out the wake count, note which notice came
   task wake(input logic v);
      int n;
      logic [1:0] s;
      n = 0; s = 0;
      while (halt === 1'b1 && n < 400) begin
         @(posedge clock); #1; n++; s |= {vec, res};
      end
      repeat (3) begin @(posedge clock); #1; s |= {vec, res}; end
      chk(n >= 255 && n <= 272, 1);
      chk(s, v ? 2'b10 : 2'b01);
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // hang guard
   always @(posedge clock) begin
      cyc_n++;
      if (cyc_n == 8000) begin n_fail++; tally_and_finish; end
   end
   initial begin
      repeat (6) @(posedge clock);
      rst_n <= 1;
      xfer(0, `SSPC_KEY_OFFSET, 0); chk(rd, `SSPC_KEY_RESET);
      xfer(0, 8'h10, 0); chk(rd, 0);
      chk({halt, tclk, pclk}, 3'b011);
      xfer(1, `SSPC_CTRL_OFFSET, 0);
      lf = lfsr(lf); kv = lf[7:0];
      if (kv == `SSPC_KEY_STOP || kv == `SSPC_KEY_SLEEP) kv = 8'h33;
      xfer(1, `SSPC_KEY_OFFSET, kv);
      @(posedge clock) si <= 1;
      @(posedge clock) si <= 0;
      repeat (3) @(posedge clock);
      #1 chk(halt, 0);
      $display("stray key done");
      gie <= 1;
      xfer(1, `SSPC_KEY_OFFSET, `SSPC_KEY_SLEEP); chk({halt, pclk, mosc, sosc}, 4'hF);
      @(posedge clock) irqp <= 1;
      wake(1);
      irqp <= 0;
      xfer(0, `SSPC_CTRL_OFFSET, 0); chk(rd[7:0], 0);
      xfer(0, `SSPC_STATUS_OFFSET, 0); chk(rd[2:0], 3'b000);
      $display("sleep done");
      for (int i = 0; i < 6; i++) begin
         ctrl_m = i % 4;
         xfer(1, `SSPC_CTRL_OFFSET, 8'(ctrl_m));
         lf = lfsr(lf); gie <= lf[0];
         xfer(1, `SSPC_KEY_OFFSET, `SSPC_KEY_STOP);
         @(posedge clock) si <= 1;
         @(posedge clock) si <= 0;
         #1 chk({halt, pclk, mosc, sosc, spclk, sclk, tclk},
            {2'b10, ctrl_m[0], !ctrl_m[0], !ctrl_m[0], ctrl_m[1], 1'b1});
         @(posedge clock) if (i == 5) ext <= 1; else src <= 5'(1 << i);
         @(posedge clock) src <= 0;
         wake(lf[0]);
         ext <= 0;
         xfer(0, `SSPC_KEY_OFFSET, 0); chk(rd, 0);
         xfer(0, `SSPC_STATUS_OFFSET, 0); chk(rd[2:0], 3'b100);
         xfer(0, `SSPC_CTRL_OFFSET, 0); chk(rd[1:0], ctrl_m[1:0]);
         $display("stop %0d done", i);
      end
      xfer(1, `SSPC_KEY_OFFSET, `SSPC_KEY_SLEEP);
      @(posedge clock) rst_n <= 0;
      @(posedge clock) rst_n <= 1;
      #1 chk(halt, 0);
      xfer(0, `SSPC_KEY_OFFSET, 0); chk(rd, `SSPC_KEY_RESET);
      xfer(0, `SSPC_CTRL_OFFSET, 0); chk(rd[7:0], {`SSPC_NWAKE, 4'h0});
      $display("reset wake done");
      tally_and_finish;
   end
endmodule
